// ### inc/fifo_stat_pkg.sv
// Purpose: Shared constants for the FIFO status and event queue block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Registers are 16 bits wide and sit in the low half of the word.
package fifo_stat_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] fifo_control_low_addr        = 8'h00;
  localparam logic [7:0] fifo_status_addr             = 8'h04;
  localparam logic [7:0] event_fifo_control_high_addr = 8'h08;
  localparam logic [7:0] event_fifo_control_low_addr  = 8'h0c;
  localparam logic [7:0] fifo_depth_code_addr         = 8'h10;
  localparam logic [7:0] event_fifo_status_addr       = 8'h14;
  localparam int reg_width = 16;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int queue_reset_bit    = 10;
  localparam int send_request_bit   = 9;
  localparam int tail_advance_bit   = 8;
  localparam int direction_tx_bit   = 7;
  localparam int index_lsb          = 8;
  localparam int index_msb          = 12;
  localparam int aborted_bit        = 7;
  localparam int arb_lost_bit       = 6;
  localparam int bus_error_bit      = 5;
  localparam int attempts_bit       = 4;
  localparam int overflow_bit       = 3;
  localparam int timestamp_bit      = 5;
  localparam int ctl_low_mask_w     = 8;
  localparam int irq_en_w           = 4;
  localparam int level_en_w         = 3;
  localparam int index_w            = 5;
  localparam logic [4:0] depth_code_reset = 5'h00;
endpackage

// ### inc/occ_if.sv
// Purpose: Carries one queue's occupancy between the counter and the top.
// Assumes: Single clock domain.
// Notes:   The counter drives the pointer state, the top drives commands.
`timescale 1ns/10ps
interface occ_if;
  logic [4:0] depth_code;
  logic       push;
  logic       pop;
  logic       clear;
  logic [4:0] head;
  logic [4:0] tail;
  logic [5:0] count;
  logic       empty;
  logic       full;
  logic       half_up;
  logic       half_down;
  logic       overflow;
  modport counter (input depth_code, push, pop, clear,
                   output head, tail, count, empty, full, half_up,
                   half_down, overflow);
  modport user    (output depth_code, push, pop, clear,
                   input head, tail, count, empty, full, half_up,
                   half_down, overflow);
endinterface

// ### verilog/occ_counter.sv
// Purpose: Head, tail and occupancy count of one circular message queue.
// Assumes: Depth is the depth code plus one, at most 32 slots.
// Notes:   A push into a full queue with no pop in the same cycle is dropped and flagged as overflow.
`timescale 1ns/10ps
module occ_counter (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  occ_if.counter    q
);
  // ****************************************************************
  // Occupancy
  // ****************************************************************
  logic [5:0] depth;
  logic       do_push;
  logic       do_pop;
  logic [4:0] next_head;
  logic [4:0] next_tail;
  assign depth       = {1'b0, q.depth_code} + 6'h01;
  assign q.empty     = (q.count == 6'h00);
  assign q.full      = (q.count == depth);
  assign q.half_up   = ({q.count, 1'b0} >= {1'b0, depth});
  assign q.half_down = ({q.count, 1'b0} <= {1'b0, depth});
  assign q.overflow  = q.push && q.full && !q.pop;
  assign do_push     = q.push && !q.overflow;
  assign do_pop      = q.pop && !q.empty;
  // Wrap at depth minus one so the slot index never leaves the window.
  assign next_head = (q.head == q.depth_code) ? 5'h00 : q.head + 5'h01;
  assign next_tail = (q.tail == q.depth_code) ? 5'h00 : q.tail + 5'h01;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q.head  <= 5'h00;
      q.tail  <= 5'h00;
      q.count <= 6'h00;
    end else if (clk_en) begin
      if (q.clear) begin
        q.head  <= 5'h00;
        q.tail  <= 5'h00;
        q.count <= 6'h00;
      end else begin
        if (do_push) q.head <= next_head;
        if (do_pop)  q.tail <= next_tail;
        q.count <= q.count + {5'h00, do_push} - {5'h00, do_pop};
      end
    end
  end
endmodule

// ### verilog/fifo_status_ctrl.sv
// Purpose: Status, enables and event-queue control of one message FIFO.
// Assumes: APB slave, 32-bit data, zero-wait answers; engine is logic.
// Notes:   The engine reports slot moves and outcomes by one-cycle pulses.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module fifo_status_ctrl (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        msg_slot_push,
  input  wire logic        msg_slot_pop,
  input  wire logic        msg_done,
  input  wire logic        msg_abort_done,
  input  wire logic        msg_arb_lost,
  input  wire logic        msg_bus_error,
  input  wire logic        msg_attempts_out,
  input  wire logic        event_push,
  output logic             fifo_direction_tx,
  output logic             send_request,
  output logic             event_timestamp_enable,
  output logic             fifo_irq,
  output logic             event_irq
);
  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic        acc;
  logic        wr;
  logic        rd;
  logic        hit_ctl;
  logic        hit_sta;
  logic        hit_eh;
  logic        hit_el;
  logic        hit_dc;
  logic        hit_es;
  logic        mapped;
  logic [15:0] wdata;
  assign acc     = psel && penable;
  assign wr      = acc && pwrite;
  assign rd      = acc && !pwrite;
  assign hit_ctl = (paddr == fifo_stat_pkg::fifo_control_low_addr);
  assign hit_sta = (paddr == fifo_stat_pkg::fifo_status_addr);
  assign hit_eh  = (paddr == fifo_stat_pkg::event_fifo_control_high_addr);
  assign hit_el  = (paddr == fifo_stat_pkg::event_fifo_control_low_addr);
  assign hit_dc  = (paddr == fifo_stat_pkg::fifo_depth_code_addr);
  assign hit_es  = (paddr == fifo_stat_pkg::event_fifo_status_addr);
  assign mapped  = hit_ctl || hit_sta || hit_eh || hit_el || hit_dc
                   || hit_es;
  assign wdata   = pwdata[fifo_stat_pkg::reg_width-1:0];
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  // ****************************************************************
  // Mode selection
  // ****************************************************************
  // Every dual-meaning source except slot_index passes through here; a change of
  // direction retargets all of them, slot_index too, in the same cycle.
  function automatic logic by_mode(input logic tx_mode,
                                   input logic tx_val,
                                   input logic rx_val);
    by_mode = tx_mode ? tx_val : rx_val;
  endfunction

  // ****************************************************************
  // Control registers
  // ****************************************************************
  logic [7:0] ctl_low;
  logic       queue_reset;
  logic [4:0] depth_code;
  logic [4:0] event_depth_code;
  logic       event_queue_reset;
  logic [3:0] event_irq_en;
  logic       event_overflow_flag;
  logic       wr_ctl;
  logic       wr_el;
  logic       req_set;
  logic       tail_advance;
  logic       event_tail_advance;
  logic       ctl_el_ts;
  occ_if      msg_q ();
  occ_if      evt_q ();
  assign wr_ctl  = wr && hit_ctl;
  assign wr_el   = wr && hit_el;
  assign req_set = wr_ctl && wdata[fifo_stat_pkg::send_request_bit];
  assign tail_advance       = wr_ctl && wdata[fifo_stat_pkg::tail_advance_bit];
  assign event_tail_advance = wr_el && wdata[fifo_stat_pkg::tail_advance_bit];
  assign fifo_direction_tx = ctl_low[fifo_stat_pkg::direction_tx_bit];
  assign event_timestamp_enable = ctl_el_ts;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_low      <= 8'h00;
      depth_code   <= fifo_stat_pkg::depth_code_reset;
      event_depth_code <= fifo_stat_pkg::depth_code_reset;
      event_irq_en <= 4'h0;
      ctl_el_ts    <= 1'b0;
    end else if (clk_en) begin
      if (wr_ctl) ctl_low <= wdata[fifo_stat_pkg::ctl_low_mask_w-1:0];
      if (wr && hit_dc) depth_code <= wdata[fifo_stat_pkg::index_w-1:0];
      if (wr && hit_eh)
        event_depth_code <= wdata[fifo_stat_pkg::index_msb:
                                  fifo_stat_pkg::index_lsb];
      if (wr_el) begin
        event_irq_en <= wdata[fifo_stat_pkg::irq_en_w-1:0];
        ctl_el_ts    <= wdata[fifo_stat_pkg::timestamp_bit];
      end
    end
  end

  // The reset request is registered, so the queue clears one edge
  // after the write and the bit reads back high for that cycle.
  // self-clearing reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      queue_reset       <= 1'b0;
      event_queue_reset <= 1'b0;
    end else if (clk_en) begin
      queue_reset <= wr_ctl && wdata[fifo_stat_pkg::queue_reset_bit];
      event_queue_reset <= wr_el && wdata[fifo_stat_pkg::queue_reset_bit];
    end
  end

  // A send request stays until the queue drains or software clears it.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      send_request <= 1'b0;
    end else if (clk_en) begin
      if (queue_reset || !fifo_direction_tx)
        send_request <= 1'b0;
      else if (wr_ctl)
        send_request <= wdata[fifo_stat_pkg::send_request_bit];
      else if (msg_done && msg_q.count == 6'h01)
        send_request <= 1'b0;
    end
  end

  // ****************************************************************
  // Occupancy of both queues
  // ****************************************************************
  logic tx_push;
  logic tx_pop;
  // In transmit mode software fills slots and the engine drains them;
  // in receive mode the two roles swap.
  // transmit slot moves on send
  assign tx_push = by_mode(fifo_direction_tx, tail_advance, msg_slot_push);
  assign tx_pop  = by_mode(fifo_direction_tx, msg_slot_pop, tail_advance);
  assign msg_q.depth_code = depth_code;
  assign msg_q.push       = tx_push;
  assign msg_q.pop        = tx_pop;
  assign msg_q.clear      = queue_reset;
  assign evt_q.depth_code = event_depth_code;
  assign evt_q.push       = event_push;
  assign evt_q.pop        = event_tail_advance;
  assign evt_q.clear      = event_queue_reset;

  occ_counter u_msg_q (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .q        (msg_q)
  );
  occ_counter u_evt_q (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .q        (evt_q)
  );

  // ****************************************************************
  // Status flags
  // ****************************************************************
  logic       aborted;
  logic       arb_lost;
  logic       bus_error;
  logic       attempts_flag;
  logic       overflow_flag;
  logic [4:0] slot_index;
  logic [2:0] level_flags;
  logic [2:0] level_en;
  logic       rd_sta;
  logic       msg_end;
  logic       sta_wr_clr;
  assign rd_sta     = rd && hit_sta;
  assign sta_wr_clr = wr && hit_sta;
  assign msg_end    = msg_done || msg_abort_done;
  assign slot_index = fifo_direction_tx ? msg_q.tail : msg_q.head;
  assign level_flags[2] = by_mode(fifo_direction_tx, msg_q.empty,
                                  msg_q.full);
  assign level_flags[1] = by_mode(fifo_direction_tx, msg_q.half_down,
                                  msg_q.half_up);
  assign level_flags[0] = by_mode(fifo_direction_tx, !msg_q.full,
                                  !msg_q.empty);
  assign level_en = ctl_low[fifo_stat_pkg::level_en_w-1:0];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aborted <= 1'b0;
    end else if (clk_en) begin
      if (msg_abort_done)
        aborted <= 1'b1;
      else if (rd_sta || queue_reset || req_set || sta_wr_clr)
        aborted <= 1'b0;
      else if (msg_done)
        aborted <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      arb_lost  <= 1'b0;
      bus_error <= 1'b0;
    end else if (clk_en) begin
      if (queue_reset) begin
        arb_lost  <= 1'b0;
        bus_error <= 1'b0;
      end else if (msg_end) begin
        arb_lost  <= msg_arb_lost;
        bus_error <= msg_bus_error;
      end
    end
  end

  // Sticky flags: a set in the same cycle as a clear wins.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      attempts_flag       <= 1'b0;
      overflow_flag       <= 1'b0;
      event_overflow_flag <= 1'b0;
    end else if (clk_en) begin
      if (fifo_direction_tx && msg_attempts_out)
        attempts_flag <= 1'b1;
      else if (sta_wr_clr && !wdata[fifo_stat_pkg::attempts_bit])
        attempts_flag <= 1'b0;
      if (!fifo_direction_tx && msg_q.overflow)
        overflow_flag <= 1'b1;
      else if (sta_wr_clr && !wdata[fifo_stat_pkg::overflow_bit])
        overflow_flag <= 1'b0;
      if (evt_q.overflow)
        event_overflow_flag <= 1'b1;
      else if ((wr && hit_es && !wdata[fifo_stat_pkg::overflow_bit])
               || event_queue_reset)
        event_overflow_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // Interrupts and read data
  // ****************************************************************
  logic [15:0] sta_word;
  logic [15:0] ctl_word;
  logic [15:0] el_word;
  logic [3:0]  evt_flags;
  logic [15:0] rd_word;
  assign evt_flags = {event_overflow_flag, evt_q.full, evt_q.half_up,
                      !evt_q.empty};
  logic [fifo_stat_pkg::level_en_w-1:0] level_irq;
  logic [fifo_stat_pkg::irq_en_w-1:0]   evt_irq_bits;
  generate
    for (genvar gi = 0; gi < fifo_stat_pkg::level_en_w; gi++) begin : g_lvl
      assign level_irq[gi] = level_flags[gi] && level_en[gi];
    end
    for (genvar gj = 0; gj < fifo_stat_pkg::irq_en_w; gj++) begin : g_evt
      assign evt_irq_bits[gj] = evt_flags[gj] && event_irq_en[gj];
    end
  endgenerate

  assign fifo_irq  = |level_irq;
  assign event_irq = |evt_irq_bits;
  assign sta_word = {3'h0, slot_index, aborted, arb_lost, bus_error,
                     attempts_flag && fifo_direction_tx,
                     overflow_flag && !fifo_direction_tx, level_flags};
  assign ctl_word = {5'h00, queue_reset, send_request, 1'b0, ctl_low};
  assign el_word  = {5'h00, event_queue_reset, 4'h0, ctl_el_ts, 1'b0,
                     event_irq_en};
  assign rd_word  = hit_ctl ? ctl_word :
                    hit_sta ? sta_word :
                    hit_eh  ? {3'h0, event_depth_code, 8'h00} :
                    hit_el  ? el_word :
                    hit_dc  ? {11'h000, depth_code} :
                    hit_es  ? {12'h000, evt_flags} : 16'h0000;

  // Read data is taken in the setup cycle, so it stands unchanged
  // through the access phase even when that read clears a status bit.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      prdata <= {16'h0000, rd_word};
    end
  end
endmodule

// ### testbench/fifo_status_ctrl_monitor.sv
// Purpose: Port-level checks of the FIFO status block.
// Assumes: One clock domain; writes land on the APB access edge.
// Notes:   Bound to every fifo_status_ctrl instance.
`timescale 1ns/10ps
module fifo_status_ctrl_monitor (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        fifo_direction_tx,
  input wire logic        event_timestamp_enable,
  input wire logic        fifo_irq,
  input wire logic        event_irq
);
  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  wire acc    = psel && penable && clk_en;
  wire wr_ctl = acc && pwrite && paddr == fifo_stat_pkg::fifo_control_low_addr;
  wire wr_evc = acc && pwrite
                && paddr == fifo_stat_pkg::event_fifo_control_low_addr;
  wire rd_sta = acc && !pwrite && paddr == fifo_stat_pkg::fifo_status_addr;
  a_dir_follows_write: assert property (
    wr_ctl |=> fifo_direction_tx == $past(pwdata[7]))
    else $error("direction bit did not follow write");
  a_ts_follows_write: assert property (
    wr_evc |=> event_timestamp_enable == $past(pwdata[5]))
    else $error("timestamp enable did not follow write");
  a_irq_off_masked: assert property (
    wr_ctl && pwdata[4:0] == 5'h00 |=> !fifo_irq)
    else $error("fifo interrupt with all enables clear");
  a_evirq_off_masked: assert property (
    wr_evc && pwdata[3:0] == 4'h0 |=> !event_irq)
    else $error("event interrupt with all enables clear");
  a_rx_attempts_zero: assert property (
    rd_sta && !fifo_direction_tx |-> !prdata[4])
    else $error("attempts flag seen in receive mode");
  a_tx_overflow_zero: assert property (
    rd_sta && fifo_direction_tx |-> !prdata[3])
    else $error("overflow flag seen in transmit mode");
  a_status_upper_zero: assert property (
    rd_sta |-> prdata[31:13] == 19'h00000)
    else $error("status bits above the index not zero");
  a_irq_quiet_reset: assert property (
    $rose(rst_n) |-> !fifo_irq && !event_irq)
    else $error("interrupt raised straight after reset");
  a_unmapped_refused: assert property (
    acc && paddr > 8'h14 |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  c_fifo_irq: cover property (fifo_irq);
  c_event_irq: cover property (event_irq);
  c_refused: cover property (acc && pslverr);
endmodule

bind fifo_status_ctrl fifo_status_ctrl_monitor mon (
  .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pslverr(pslverr), .fifo_direction_tx(fifo_direction_tx),
  .event_timestamp_enable(event_timestamp_enable), .fifo_irq(fifo_irq),
  .event_irq(event_irq));

// ### testbench/can_engine_model.sv
// Purpose: Behavioural model of the protocol engine and message store.
// Assumes: Every report is a one-cycle pulse on core_clk.
// Notes:   Outcome levels are inverted while idle, so stale values show.
`timescale 1ns/10ps
module can_engine_model (
  input  wire logic core_clk,
  output logic      slot_push,
  output logic      slot_pop,
  output logic      done,
  output logic      abort_done,
  output logic      arb_lost,
  output logic      bus_error,
  output logic      attempts_out,
  output logic      ev_push
);
  // ****************************************************************
  // Reports
  // ****************************************************************
  initial begin
    {slot_push, slot_pop, done, abort_done, attempts_out, ev_push} = 6'h00;
    {arb_lost, bus_error} = 2'h3;
  end
  // Kind 0 stores a message, 1 writes an event, 2 exhausts attempts.
  task automatic pulse(input int kind, input int gap);
    repeat (gap + 1) @(posedge core_clk);
    slot_push    <= (kind == 0);
    ev_push      <= (kind == 1);
    attempts_out <= (kind == 2);
    @(posedge core_clk);
    {slot_push, ev_push, attempts_out} <= 3'h0;
    #1;
  endtask
  // outcome levels valid only with the outcome pulse
  task automatic finish(input logic ok, input logic al, input logic be,
                        input int gap);
    repeat (gap + 1) @(posedge core_clk);
    {done, slot_pop, abort_done} <= {ok, ok, !ok};
    {arb_lost, bus_error} <= {al, be};
    @(posedge core_clk);
    {done, slot_pop, abort_done} <= 3'h0;
    {arb_lost, bus_error} <= {!al, !be};
    #1;
  endtask
endmodule

// ### testbench/testbench.sv
// Purpose: Self-checking bench for the FIFO status block.
// Assumes: Zero-wait APB slave; the engine is a behavioural model.
// Notes:   clk_en stays high, so bus stalls are not exercised here.
`timescale 1ns/10ps
module testbench;
  // ****************************************************************
  // Wiring
  // ****************************************************************
  logic        core_clk = 1'h0;
  logic        rst_n    = 1'h0;
  logic        clk_en   = 1'h1;
  logic        psel     = 1'h0;
  logic        penable  = 1'h0;
  logic        pwrite   = 1'h0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic [31:0] prdata, rdata;
  logic        pready, pslverr, perr, push, pop, done, abrt, arb, berr;
  logic        att, evp, dir_tx, send_req, ts_en, fifo_irq, event_irq;
  int          err_count = 0;
  int          tests_run = 0;
  always #2.5 core_clk = ~core_clk;
  fifo_status_ctrl dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .msg_slot_push(push), .msg_slot_pop(pop), .msg_done(done),
    .msg_abort_done(abrt), .msg_arb_lost(arb), .msg_bus_error(berr),
    .msg_attempts_out(att), .event_push(evp), .fifo_direction_tx(dir_tx),
    .send_request(send_req), .event_timestamp_enable(ts_en),
    .fifo_irq(fifo_irq), .event_irq(event_irq));
  can_engine_model eng (.core_clk(core_clk), .slot_push(push),
    .slot_pop(pop), .done(done), .abort_done(abrt), .arb_lost(arb),
    .bus_error(berr), .attempts_out(att), .ev_push(evp));
  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  // Request held until pready is seen high with psel and penable.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge core_clk);
    penable <= 1'h1;
    @(posedge core_clk);
    while (pready !== 1'h1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    if (pready !== 1'h1) begin
      err_count++;
      $display("MISMATCH pready expected 1 seen %b", pready);
    end
    rdata = prdata;
    perr  = pslverr;
    {psel, penable} <= 2'h0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string n);
    apb(1'h0, a, 32'h0);
    chk(n, e, rdata);
  endtask
  task automatic poll_clear(input logic [7:0] a, input logic [31:0] e);
    int n;
    n = 0;
    do begin
      apb(1'h0, a, 32'h0);
      n++;
    end while (rdata[10] !== 1'h0 && n < 10);
    chk("reset_bit_cleared", e, rdata);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_map();
    for (int i = 0; i < 6; i++) begin
      rd(8'(i * 4), 32'h0, "reset_value");
    end
    apb(1'h1, 8'h20, 32'hffff);
    chk1("unmapped_write_err", 1'h1, perr);
    rd(8'h20, 32'h0, "unmapped_read");
    chk1("unmapped_read_err", 1'h1, perr);
    $display("test reset_map done");
  endtask
  task automatic t_rx();
    apb(1'h1, 8'h10, 32'h3);
    apb(1'h1, 8'h00, 32'h4);
    for (int i = 0; i < 3; i++) begin
      eng.pulse(0, i);
    end
    rd(8'h04, 32'h0303, "rx_three_stored");
    chk1("irq_not_full", 1'h0, fifo_irq);
    eng.pulse(0, 0);
    rd(8'h04, 32'h0007, "rx_full_wrapped");
    for (int b = 0; b < 3; b++) begin
      apb(1'h1, 8'h00, 32'h1 << b);
      chk1("rx_irq_enable", 1'h1, fifo_irq);
    end
    eng.pulse(0, 0);
    rd(8'h04, 32'h000f, "rx_overflow");
    apb(1'h1, 8'h04, 32'h0);
    rd(8'h04, 32'h0007, "overflow_cleared");
    apb(1'h1, 8'h00, 32'h0);
    chk1("irq_masked", 1'h0, fifo_irq);
    $display("test rx done");
  endtask
  task automatic t_tx();
    apb(1'h1, 8'h00, 32'h0480);
    poll_clear(8'h00, 32'h0080);
    rd(8'h04, 32'h0007, "tx_empty");
    apb(1'h1, 8'h00, 32'h0180);
    apb(1'h1, 8'h00, 32'h0180);
    rd(8'h04, 32'h0003, "tx_two_queued");
    eng.finish(1'h1, 1'h1, 1'h0, 2);
    rd(8'h04, 32'h0143, "tx_sent_arb_lost");
    eng.finish(1'h0, 1'h0, 1'h1, 0);
    rd(8'h04, 32'h01a3, "tx_aborted");
    rd(8'h04, 32'h0123, "abort_read_clear");
    eng.finish(1'h0, 1'h0, 1'h1, 0);
    apb(1'h1, 8'h00, 32'h0280);
    chk1("send_request", 1'h1, send_req);
    rd(8'h04, 32'h0123, "abort_request_clear");
    eng.pulse(2, 1);
    rd(8'h04, 32'h0133, "attempts_set");
    apb(1'h1, 8'h04, 32'h0);
    rd(8'h04, 32'h0123, "attempts_cleared");
    $display("test tx done");
  endtask
  task automatic t_event();
    apb(1'h1, 8'h08, 32'h0100);
    rd(8'h08, 32'h0100, "event_depth");
    apb(1'h1, 8'h0c, 32'h002f);
    chk1("timestamp_on", 1'h1, ts_en);
    eng.pulse(1, 3);
    rd(8'h14, 32'h3, "event_one");
    eng.pulse(1, 0);
    rd(8'h14, 32'h7, "event_full");
    eng.pulse(1, 0);
    rd(8'h14, 32'hf, "event_overflow");
    for (int b = 0; b < 4; b++) begin
      apb(1'h1, 8'h0c, 32'h20 | (32'h1 << b));
      chk1("event_irq_enable", 1'h1, event_irq);
    end
    apb(1'h1, 8'h0c, 32'h012f);
    rd(8'h14, 32'hb, "event_tail_step");
    apb(1'h1, 8'h0c, 32'h002f);
    rd(8'h14, 32'hb, "event_tail_hold");
    apb(1'h1, 8'h0c, 32'h042f);
    poll_clear(8'h0c, 32'h002f);
    rd(8'h14, 32'h0, "event_after_reset");
    apb(1'h1, 8'h0c, 32'h0);
    eng.pulse(1, 0);
    chk1("event_irq_masked", 1'h0, event_irq);
    chk1("timestamp_off", 1'h0, ts_en);
    $display("test event done");
  endtask
  // ****************************************************************
  // Sequence and verdict
  // ****************************************************************
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'h1;
    t_reset_map();
    t_rx();
    t_tx();
    t_event();
    print_verdict();
  end
  // The full run takes well under 2000 cycles.
  initial begin
    #50000;
    err_count++;
    $display("MISMATCH watchdog expected finish seen timeout");
    print_verdict();
  end
endmodule
